// ==== verilog/path_overhead_alarm_monitor.v ====
// Purpose: Receive path overhead alarm, label and error count register bank
// Assumes: Path inputs come from logic on clk; Avalon-MM slave with waitrequest
// Notes:   Every request waits one cycle; polls latch counts within one cycle
//
// Notes on behaviour
// - Far-end error enabled: far-end errors raise the interrupt output.
// - Parity error enabled: path parity errors raise the interrupt output.
// - Remote-defect enabled: any remote defect state change raises the interrupt.
// - Alarm-indication enabled: any path AIS state change raises the interrupt.
// - Pointer-loss enabled: any loss-of-pointer state change raises the interrupt.
// - Label-change enabled: any accepted label change raises the interrupt.
// - Enable register: six enables plus reserved bits 6 and 4, all reset zero.
// - Read-only register returns the accepted received path signal label.
// - New label accepted only after three consecutive identical frames.
// - Path parity errors since last poll, 16 bits over low and high bytes.
// - Far-end block errors since last poll, 16 bits over low and high bytes.
// - Writing any of the four count addresses polls both counts.
// - Poll copies accumulators to holding registers and restarts them together.
// - Errors coinciding with a poll are counted in the new interval.
// - Writing the load-meters address also polls, plus all other device counters.
// - Block mode: at most one parity error per frame, counted and reported.
// - Bit mode, the reset state: one parity error per mismatching bit.
// - Pointer-loss, AIS and remote-defect flags set on any state transition.
// - Reading the status register clears its flags and their interrupt.
// - Label-change flag set whenever the accepted label changes.
//
// The implementer's own choice: the Avalon-MM interface to the registers.

`include "path_overhead_alarm_monitor_map.vh"

`default_nettype none

module path_overhead_alarm_monitor (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Avalon-MM slave
  input  wire [9:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Received label byte, one strobe per frame
  input  wire        labelValid,
  input  wire [7:0]  labelByte,
  // Parity check result, one strobe per frame
  input  wire        parityValid,
  input  wire [7:0]  parityMismatch,
  // Far-end block error count from the status byte, one strobe per frame
  input  wire        farErrorValid,
  input  wire [3:0]  farErrorNum,
  // Current alarm states
  input  wire        pointerLossState,
  input  wire        alarmIndicationState,
  input  wire        remoteDefectState,
  // Interrupt and reporting
  output reg         irq,
  output reg         loadAllMeters,
  output reg         parityReportValid,
  output reg  [3:0]  parityReportCount
);

  // ============================================================
  // Functions

  // Number of set bits in a parity mismatch vector
  function [3:0] popCount;
    input [7:0] v;
    integer i;
    begin
      popCount = 4'h0;
      for (i = 0; i < 8; i = i + 1) begin
        popCount = popCount + {3'h0, v[i]};
      end
    end
  endfunction

  // Saturating 16-bit add of a small increment
  function [15:0] satAdd;
    input [15:0] base;
    input [3:0]  inc;
    reg   [16:0] sum;
    begin
      sum = {1'b0, base} + {13'h0000, inc};
      satAdd = sum[16] ? 16'hffff : sum[15:0];
    end
  endfunction

  // ============================================================
  // Declarations
  reg  [7:0]  irqEnable_q;
  reg  [7:0]  parityConfig_q;
  reg  [7:0]  irqStatus_q;
  reg  [7:0]  irqStatus_d;
  reg  [7:0]  accepted_label_q;
  reg  [7:0]  labelCandidate_q;
  reg  [1:0]  labelRepeat_q;
  reg         labelChange;
  reg  [15:0] parityAcc_q;
  reg  [15:0] farAcc_q;
  reg  [15:0] parity_error_count_q;
  reg  [15:0] far_error_count_q;
  reg         pointerLossPrev_q;
  reg         alarmIndicationPrev_q;
  reg         remoteDefectPrev_q;
  reg  [7:0]  readMux;
  reg  [7:0]  setMask;
  wire [7:0]  regIndex;
  wire        aligned;
  wire        writeAccept;
  wire        readAccept;
  wire        blockMode;
  wire [3:0]  parityInc;
  wire [3:0]  farInc;
  wire        pollCounts;
  wire [1:0]  labelRepeatNext;

  // ============================================================
  // Bus decode

  // Word index from byte address; misaligned addresses are unmapped
  assign regIndex = address[9:2];
  assign aligned  = (address[1:0] == 2'b00);

  // A request takes effect on the edge that samples waitrequest low
  assign writeAccept = write & ~waitrequest;
  assign readAccept  = read & ~waitrequest;

  // Polls come from the four count addresses or the load-meters address
  assign pollCounts = writeAccept & aligned &
                      ((regIndex == `IDX_PARITY_CNT_LOW) |
                       (regIndex == `IDX_PARITY_CNT_HIGH) |
                       (regIndex == `IDX_FAR_CNT_LOW) |
                       (regIndex == `IDX_FAR_CNT_HIGH) |
                       (regIndex == `IDX_LOAD_METERS));

  // Read data selection; unmapped and unused bits read as zero, except enable bits 6 and 4 and configuration bits other than 3, which read back as written
  always @* begin
    readMux = 8'h00;
    if (aligned) begin
      case (regIndex)
        `IDX_PATH_STATUS: begin
          readMux[`BIT_POINTER_LOSS]     = pointerLossPrev_q;
          readMux[`BIT_ALARM_INDICATION] = alarmIndicationPrev_q;
          readMux[`BIT_REMOTE_DEFECT]    = remoteDefectPrev_q;
        end
        `IDX_PATH_IRQ_STATUS: readMux = irqStatus_q;
        `IDX_PATH_IRQ_ENABLE: readMux = irqEnable_q;
        `IDX_LABEL_RX:        readMux = accepted_label_q;
        `IDX_PARITY_CNT_LOW:  readMux = parity_error_count_q[7:0];
        `IDX_PARITY_CNT_HIGH: readMux = parity_error_count_q[15:8];
        `IDX_FAR_CNT_LOW:     readMux = far_error_count_q[7:0];
        `IDX_FAR_CNT_HIGH:    readMux = far_error_count_q[15:8];
        `IDX_PARITY_CONFIG:   readMux = parityConfig_q & `CONFIG_UNUSED_MASK;
        default:              readMux = 8'h00;
      endcase
    end
  end

  // One wait cycle per request; read data captured in that wait cycle
  always @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        readdata <= {24'h000000, readMux};
      end
    end
  end

  // ============================================================
  // Writable registers

  // Enable and configuration bytes, low byte lane only
  always @(posedge clk) begin
    if (srst) begin
      irqEnable_q    <= `RST_IRQ_ENABLE;
      parityConfig_q <= `RST_PARITY_CONFIG;
    end else if (writeAccept & aligned & byteenable[0]) begin
      if (regIndex == `IDX_PATH_IRQ_ENABLE) begin
        irqEnable_q <= writedata[7:0];
      end
      if (regIndex == `IDX_PARITY_CONFIG) begin
        parityConfig_q <= writedata[7:0] & `CONFIG_UNUSED_MASK;
      end
    end
  end

  // Global meter load pulse toward the other counter blocks
  always @(posedge clk) begin
    if (srst) begin
      loadAllMeters <= 1'b0;
    end else begin
      loadAllMeters <= writeAccept & aligned & (regIndex == `IDX_LOAD_METERS);
    end
  end

  // ============================================================
  // Label filter

  assign labelRepeatNext = labelRepeat_q + 2'd1;

  // Candidate must repeat on consecutive frames before acceptance
  always @(posedge clk) begin
    if (srst) begin
      accepted_label_q <= `RST_LABEL;
      labelCandidate_q <= `RST_LABEL;
      labelRepeat_q    <= 2'd0;
      labelChange      <= 1'b0;
    end else begin
      labelChange <= 1'b0;
      if (labelValid) begin
        if (labelByte == accepted_label_q) begin
          labelRepeat_q <= 2'd0;
        end else if (labelByte == labelCandidate_q && labelRepeat_q != 2'd0) begin
          if (labelRepeatNext == `LABEL_REPEAT_FRAMES) begin
            accepted_label_q <= labelByte;
            labelRepeat_q    <= 2'd0;
            labelChange      <= 1'b1;
          end else begin
            labelRepeat_q <= labelRepeatNext;
          end
        end else begin
          labelCandidate_q <= labelByte;
          labelRepeat_q    <= 2'd1;
        end
      end
    end
  end

  // ============================================================
  // Error accumulation

  // Bit mode counts mismatching bits, block mode one per bad frame
  assign blockMode = parityConfig_q[`BIT_BLOCK_PARITY];
  assign parityInc = ~parityValid ? 4'h0 :
                     blockMode ? {3'h0, |parityMismatch} :
                     popCount(parityMismatch);
  assign farInc    = farErrorValid ? farErrorNum : 4'h0;

  // Per-frame parity report toward the return transmit side
  always @(posedge clk) begin
    if (srst) begin
      parityReportValid <= 1'b0;
      parityReportCount <= 4'h0;
    end else begin
      parityReportValid <= parityValid;
      parityReportCount <= parityInc;
    end
  end

  // Accumulators with poll transfer; a coincident event opens the new interval
  always @(posedge clk) begin
    if (srst) begin
      parityAcc_q          <= `RST_COUNT;
      farAcc_q             <= `RST_COUNT;
      parity_error_count_q <= `RST_COUNT;
      far_error_count_q    <= `RST_COUNT;
    end else if (pollCounts) begin
      parity_error_count_q <= parityAcc_q;
      far_error_count_q    <= farAcc_q;
      parityAcc_q          <= {12'h000, parityInc};
      farAcc_q             <= {12'h000, farInc};
    end else begin
      parityAcc_q <= satAdd(parityAcc_q, parityInc);
      farAcc_q    <= satAdd(farAcc_q, farInc);
    end
  end

  // ============================================================
  // Alarm edges and interrupt status

  // Previous alarm states, also shown in the path status register
  always @(posedge clk) begin
    if (srst) begin
      pointerLossPrev_q     <= 1'b0;
      alarmIndicationPrev_q <= 1'b0;
      remoteDefectPrev_q    <= 1'b0;
    end else begin
      pointerLossPrev_q     <= pointerLossState;
      alarmIndicationPrev_q <= alarmIndicationState;
      remoteDefectPrev_q    <= remoteDefectState;
    end
  end

  // Event set mask; reads clear only bits already shown, set wins
  always @* begin
    setMask = 8'h00;
    setMask[`BIT_FAR_ERROR]        = (farInc != 4'h0);
    setMask[`BIT_PARITY_ERROR]     = (parityInc != 4'h0);
    setMask[`BIT_REMOTE_DEFECT]    = remoteDefectState ^ remoteDefectPrev_q;
    setMask[`BIT_ALARM_INDICATION] = alarmIndicationState ^ alarmIndicationPrev_q;
    setMask[`BIT_POINTER_LOSS]     = pointerLossState ^ pointerLossPrev_q;
    setMask[`BIT_LABEL_CHANGE]     = labelChange;
    irqStatus_d = irqStatus_q;
    if (readAccept & aligned & (regIndex == `IDX_PATH_IRQ_STATUS)) begin
      irqStatus_d = irqStatus_q & ~readdata[7:0];
    end
    irqStatus_d = irqStatus_d | setMask;
  end

  // Sticky flags and the gated interrupt output
  always @(posedge clk) begin
    if (srst) begin
      irqStatus_q <= 8'h00;
      irq         <= 1'b0;
    end else begin
      irqStatus_q <= irqStatus_d;
      // Far-end, parity, remote, AIS, pointer and label events gated here
      irq <= |(irqStatus_d & irqEnable_q);
    end
  end

endmodule // path_overhead_alarm_monitor

`default_nettype wire

// ==== verilog/path_overhead_alarm_monitor_map.vh ====
// Purpose: Register word indices, field positions, reset values and timing counts
// Assumes: Byte address on the bus is four times the word index
// Notes:   Definitions only
`ifndef PATH_OVERHEAD_ALARM_MONITOR_MAP_VH
`define PATH_OVERHEAD_ALARM_MONITOR_MAP_VH

// ============================================================
// Register word indices
`define IDX_LOAD_METERS      8'h00
`define IDX_PATH_STATUS      8'h30
`define IDX_PATH_IRQ_STATUS  8'h31
`define IDX_PATH_IRQ_ENABLE  8'h33
`define IDX_LABEL_RX         8'h37
`define IDX_PARITY_CNT_LOW   8'h38
`define IDX_PARITY_CNT_HIGH  8'h39
`define IDX_FAR_CNT_LOW      8'h3a
`define IDX_FAR_CNT_HIGH     8'h3b
`define IDX_PARITY_CONFIG    8'h3d

// ============================================================
// Field positions, shared by enable and status registers, then the parity configuration fields
`define BIT_FAR_ERROR        0
`define BIT_PARITY_ERROR     1
`define BIT_REMOTE_DEFECT    2
`define BIT_ALARM_INDICATION 3
`define BIT_POINTER_LOSS     5
`define BIT_LABEL_CHANGE     7
`define BIT_BLOCK_PARITY     5
`define CONFIG_UNUSED_MASK   8'hf7

// ============================================================
// Reset values
`define RST_IRQ_ENABLE       8'h00
`define RST_PARITY_CONFIG    8'h00
`define RST_LABEL            8'h00
`define RST_COUNT            16'h0000

// ============================================================
// Label filter and timing
`define LABEL_REPEAT_FRAMES  2'd3
`define CLK_PERIOD_PS        5000
`define POLL_MAX_NS          7000
`define POLL_MAX_CYCLES      ((`POLL_MAX_NS * 1000) / `CLK_PERIOD_PS)

`endif

// ==== verification/path_overhead_alarm_monitor_asserts.sv ====
// Purpose: Port checks for the path alarm register bank
// Assumes: One clock, srst synchronous and active high
// Notes:   Bound to the design top by the statement at the foot
`default_nettype none

// ==========
// Checker
module path_overhead_alarm_monitor_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register bus
  input wire logic [9:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Path side and outputs
  input wire logic        parityValid,
  input wire logic [7:0]  parityMismatch,
  input wire logic        irq,
  input wire logic        loadAllMeters,
  input wire logic        parityReportValid,
  input wire logic [3:0]  parityReportCount
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Write taken at this edge
  wire logic accWr = write && !waitrequest;

  // Bus answer latency
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_IDLE_WAIT: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest low without a request");
  // Parity report per frame
  AST_REPORT: assert property (parityValid |=> parityReportValid)
    else $error("no parity report after a frame");
  AST_NO_REPORT: assert property (!parityValid |=> !parityReportValid)
    else $error("parity report without a frame");
  AST_ZERO_COUNT: assert property (parityValid && parityMismatch == 8'h00 |=> parityReportCount == 4'h0)
    else $error("errors reported for a clean frame");
  AST_COUNT_BOUND: assert property (parityValid && parityMismatch != 8'h00 |=>
    (parityReportCount != 4'h0) && (parityReportCount <= $countones($past(parityMismatch))))
    else $error("parity report count out of range");
  // Load pulse follows a write to index zero
  AST_LOAD_PULSE: assert property (accWr && address == 10'h000 |=> loadAllMeters ##1 !loadAllMeters)
    else $error("load pulse missing or too long");
  AST_LOAD_CAUSE: assert property (loadAllMeters |-> $past(accWr && address == 10'h000))
    else $error("load pulse without a write");
  // Interrupt falls only on status read or enable write
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(read && !waitrequest && address == 10'h0c4)
    || $past(accWr && address == 10'h0cc, 2))
    else $error("interrupt dropped without cause");
  // Main scenarios
  cover property (accWr && address == 10'h000);
  cover property ($fell(irq));
  cover property (parityValid && parityMismatch == 8'hff);
endmodule // path_overhead_alarm_monitor_asserts

bind path_overhead_alarm_monitor path_overhead_alarm_monitor_asserts chk (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .parityValid(parityValid),
  .parityMismatch(parityMismatch), .irq(irq), .loadAllMeters(loadAllMeters),
  .parityReportValid(parityReportValid), .parityReportCount(parityReportCount));
`default_nettype wire

// ==== verification/path_overhead_source.sv ====
// Purpose: Model of the incoming path overhead stream
// Assumes: Driven by task calls from the bench, on clk
// Notes:   Data lines carry inverted values between frames
`default_nettype none

// ==========
// Frame source
module path_overhead_source (
  // Clock
  input  wire logic       clk,
  // Per-frame bytes
  output var  logic       labelValid,
  output var  logic [7:0] labelByte,
  output var  logic       parityValid,
  output var  logic [7:0] parityMismatch,
  output var  logic       farErrorValid,
  output var  logic [3:0] farErrorNum,
  // Alarm levels
  output var  logic       pointerLossState,
  output var  logic       alarmIndicationState,
  output var  logic       remoteDefectState
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    {labelValid, parityValid, farErrorValid} = 3'h0;
    {labelByte, parityMismatch, farErrorNum} = 20'h5a5a5;
    {pointerLossState, alarmIndicationState, remoteDefectState} = 3'h0;
  end
  // One frame, strobes high for one cycle
  task automatic frame(input logic [7:0] lbl, input logic [7:0] mis, input logic [3:0] fe);
    @(posedge clk);
    {labelValid, parityValid, farErrorValid} <= 3'h7;
    {labelByte, parityMismatch, farErrorNum} <= {lbl, mis, fe};
    @(posedge clk);
    {labelValid, parityValid, farErrorValid} <= 3'h0;
    {labelByte, parityMismatch, farErrorNum} <= ~{lbl, mis, fe}; // Stale data inverted
  endtask
  // Alarm levels: pointer, AIS, remote
  task automatic alarms(input logic [2:0] lvl);
    @(posedge clk);
    {pointerLossState, alarmIndicationState, remoteDefectState} <= lvl;
  endtask
endmodule // path_overhead_source
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the path alarm register bank
// Assumes: 200 MHz clock, one wait cycle per bus request
// Notes:   Far count saturates after about nine thousand cycles
`default_nettype none
`include "path_overhead_alarm_monitor_map.vh"

// ==========
// Bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, read, write, irq, waitrequest;
  logic [9:0]  address;
  logic [31:0] writedata, readdata;
  logic        loadAllMeters, parityReportValid;
  logic [3:0]  parityReportCount, farErrorNum;
  logic        labelValid, parityValid, farErrorValid;
  logic [7:0]  labelByte, parityMismatch;
  logic        pointerLossState, alarmIndicationState, remoteDefectState;
  int          failures = 0;
  int          checked = 0;

  // Design and far side
  path_overhead_alarm_monitor dut (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .labelValid(labelValid), .labelByte(labelByte),
    .parityValid(parityValid), .parityMismatch(parityMismatch), .farErrorValid(farErrorValid),
    .farErrorNum(farErrorNum), .pointerLossState(pointerLossState),
    .alarmIndicationState(alarmIndicationState), .remoteDefectState(remoteDefectState),
    .irq(irq), .loadAllMeters(loadAllMeters), .parityReportValid(parityReportValid),
    .parityReportCount(parityReportCount));
  path_overhead_source src (.clk(clk), .labelValid(labelValid), .labelByte(labelByte),
    .parityValid(parityValid), .parityMismatch(parityMismatch), .farErrorValid(farErrorValid),
    .farErrorNum(farErrorNum), .pointerLossState(pointerLossState),
    .alarmIndicationState(alarmIndicationState), .remoteDefectState(remoteDefectState));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare and report
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus request, held until waitrequest low
  task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clk);
    address   <= {idx, 2'b00};
    read      <= rd;
    write     <= ~rd;
    writedata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n == 20) failures++;
    rdata = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] v;
    bus(1'b0, idx, wd, v);
  endtask
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] v;
    bus(1'b1, idx, 8'h00, v);
    check(what, 16'(exp), 16'(v));
  endtask
  task automatic rd_cnt(input logic [7:0] idx, input logic [15:0] exp, input string what);
    logic [7:0] lo, hi;
    bus(1'b1, idx, 8'h00, lo);
    bus(1'b1, idx + 8'h01, 8'h00, hi);
    check(what, exp, {hi, lo});
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // Test sequence
  initial begin
    srst = 1'b1;
    {address, read, write, writedata} = 44'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd_reg(`IDX_PATH_IRQ_ENABLE, 8'h00, "enable reset");
    rd_reg(`IDX_PARITY_CONFIG, 8'h00, "config reset");
    wr_reg(`IDX_PATH_IRQ_ENABLE, 8'hff);
    rd_reg(`IDX_PATH_IRQ_ENABLE, 8'hff, "enable rw");
    rd_reg(8'hf1, 8'h00, "unmapped");
    src.frame(8'h13, 8'h0b, 4'h5);
    @(posedge clk);
    check("bit report", 16'h0003, 16'(parityReportCount));
    src.frame(8'h13, 8'h0b, 4'h0);
    rd_reg(`IDX_LABEL_RX, 8'h00, "label early");
    src.frame(8'h13, 8'h00, 4'h0);
    rd_reg(`IDX_LABEL_RX, 8'h13, "label");
    src.alarms(3'h7);
    rd_reg(`IDX_PATH_STATUS, 8'h2c, "alarm levels");
    check("irq set", 16'h0001, 16'(irq));
    rd_reg(`IDX_PATH_IRQ_STATUS, 8'haf, "flags");
    rd_reg(`IDX_PATH_IRQ_STATUS, 8'h00, "flags cleared");
    check("irq cleared", 16'h0000, 16'(irq));
    // Masked flags raise nothing until enabled
    wr_reg(`IDX_PATH_IRQ_ENABLE, 8'h00);
    src.alarms(3'h0);
    rd_reg(`IDX_PATH_STATUS, 8'h00, "alarm low");
    check("irq masked", 16'h0000, 16'(irq));
    wr_reg(`IDX_PATH_IRQ_ENABLE, 8'h20);
    rd_reg(`IDX_LABEL_RX, 8'h13, "label held");
    check("irq enabled", 16'h0001, 16'(irq));
    rd_reg(`IDX_PATH_IRQ_STATUS, 8'h2c, "falling flags");
    // Bit mode counts and polls
    wr_reg(`IDX_PARITY_CNT_LOW, 8'h00);
    rd_cnt(`IDX_PARITY_CNT_LOW, 16'h0006, "parity count");
    rd_cnt(`IDX_FAR_CNT_LOW, 16'h0005, "far count");
    wr_reg(`IDX_FAR_CNT_HIGH, 8'h00);
    rd_cnt(`IDX_PARITY_CNT_LOW, 16'h0000, "parity restart");
    // Block mode and load meters
    wr_reg(`IDX_PARITY_CONFIG, 8'hff);
    rd_reg(`IDX_PARITY_CONFIG, 8'hf7, "config rw");
    repeat (3) src.frame(8'h13, 8'hff, 4'h0);
    @(posedge clk);
    check("block report", 16'h0001, 16'(parityReportCount));
    wr_reg(`IDX_LOAD_METERS, 8'h00);
    @(posedge clk);
    check("load pulse", 16'h0001, 16'(loadAllMeters));
    rd_cnt(`IDX_PARITY_CNT_LOW, 16'h0003, "block count");
    // Far count saturates at all ones
    repeat (4370) src.frame(8'h13, 8'h00, 4'hf);
    wr_reg(`IDX_FAR_CNT_LOW, 8'h00);
    rd_cnt(`IDX_FAR_CNT_LOW, 16'hffff, "far saturate");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
